//--- design/bcc_pkg.sv
// shared constants and types of the bus cycle clock generator
package bcc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_BUS_CYCLE_MODE = 8'h01;
  localparam logic [7:0] IDX_WAIT_STATE_CONTROL_ONE = 8'h02;
  localparam logic [7:0] IDX_DMA_MODE = 8'h0e;
  localparam logic [7:0] IDX_PLATFORM_CONFIG = 8'h10;
  localparam logic [7:0] IDX_CYCLE_STATUS = 8'h11;
  localparam int ADDR_W = 8;
  // bus_cycle_mode fields
  localparam int PROC_DIV_LSB = 0;
  localparam int BUS_DIV_LSB = 3;
  localparam int OSC_SEL_BIT = 5;
  localparam int ADDR_LATCH_BIT = 6;
  localparam int CYCLE_INHIBIT_BIT = 7;
  // processor divisor = field + 2, capped at 8; bus divisor = field + 1
  localparam logic [7:0] BUS_CYCLE_MODE_RST = 8'h0a;
  // wait_state_control_one fields
  localparam int ROM_WAIT_LSB = 0;
  localparam int RAM_WAIT_LSB = 2;
  localparam int IO_WAIT_LSB = 4;
  localparam int EXP_WAIT_LSB = 6;
  localparam logic [7:0] WAIT_STATE_RST = 8'h00;
  // dma_mode fields
  localparam int DMA_SEL_LSB = 0;
  localparam logic [7:0] DMA_MODE_RST = 8'h01;
  // platform_config fields
  localparam int SPEED_BIT = 0;
  localparam int DRAM_BIT = 1;
  localparam int RAM8_BIT = 2;
  localparam int ROM8_BIT = 3;
  localparam logic [7:0] PLATFORM_CONFIG_RST = 8'h01;
  // timer divisors from the oscillator, one per crystal
  localparam logic [4:0] TIMER_DIV_HIGH_OSC = 5'h1b;
  localparam logic [4:0] TIMER_DIV_LOW_OSC = 5'h18;
  localparam logic [4:0] DISPLAY_DIV = 5'h02;
  // base cycle lengths in ticks of their timebase
  localparam logic [3:0] MEM_BASE_TICKS = 4'h2;
  localparam logic [3:0] BUS_BASE_TICKS = 4'h3;
  // power states reported by the power management unit
  localparam logic [1:0] PWR_ON = 2'h0;
  localparam logic [1:0] PWR_DOZE = 2'h1;
  localparam logic [1:0] PWR_SUSPEND = 2'h2;
  localparam logic [1:0] PWR_OFF = 2'h3;

  typedef enum logic [2:0] {
    DEV_RAM,
    DEV_ROM0,
    DEV_ROM1,
    DEV_CARD0,
    DEV_CARD1,
    DEV_IO,
    DEV_EXPMEM,
    DEV_INTIO
  } bcc_dev_t;
endpackage

//--- design/bcc_clock_divider.sv
// divider that turns an input tick into a slower tick pulse
`timescale 1ns/10ps
`default_nettype none
module bcc_clock_divider #(
  parameter int W = 5,
  parameter logic [4:0] RESET_DIV = 5'h01
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic run,
  input wire logic tickIn,
  input wire logic [W-1:0] divisor,
  output logic tickOut
);
  logic [W-1:0] count_r;
  logic [W-1:0] curDiv_r;
  logic atEnd;

  assign atEnd = (count_r == curDiv_r - W'(1)) || (curDiv_r == '0);

  // new divisor is taken when a period ends or while run is low, never mid-period
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      count_r <= '0;
      curDiv_r <= W'(RESET_DIV);
      tickOut <= 1'b0;
    end
    else if (!run)
    begin
      count_r <= '0;
      curDiv_r <= divisor;
      tickOut <= 1'b0;
    end
    else
    begin
      tickOut <= tickIn && atEnd;
      if (tickIn)
      begin
        if (atEnd)
        begin
          count_r <= '0;
          curDiv_r <= divisor;
        end
        else
        begin
          count_r <= count_r + W'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- design/bcc_top.sv
// bus cycle generator, clock divider chain and register slave
//
// Summary of operation
// - power unit divides oscillator by one to eight
// - processor clock is power clock over two-eight
// - mode field picks processor divisor, reset four
// - ram and rom cycles count processor ticks
// - bus clock is processor over 1-4, reset two
// - io and expansion cycles count bus ticks
// - crystal select keeps timer near 1.19 MHz
// - latch enable holds address between cycles
// - inhibit drops external strobes for internal io
// - rom wait field covers both rom selects
// - ram wait field covers every ram access
// - io wait field adds bus-clock waits
// - expansion wait field adds bus-clock waits
// - dram multiplexed, all other memories latched
// - bus carries 8 or 16 bit memory, io 8 bit only
// - 8-bit ram and rom use low lanes only
// - one dma pair routed to channel 1-3
// - oscillator feeds processor, display and timer clocks
// - suspend and off stop every oscillator clock
// - expansion strobes idle for ram, rom, cards
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module bcc_top #(
  parameter int AW = 20
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [1:0] powerState,
  input wire logic reqValid,
  input wire bcc_pkg::bcc_dev_t reqType,
  input wire logic reqWrite,
  input wire logic reqWide,
  input wire logic [AW-1:0] reqAddr,
  output logic cycleDone,
  output logic [AW-1:0] addrOut,
  output logic rowPhase,
  output logic [1:0] laneEnable,
  output logic memReadStrobe_n,
  output logic memWriteStrobe_n,
  output logic rom_select_zero_n,
  output logic rom_select_one_n,
  output logic expansion_memory_read_strobe_n,
  output logic expansion_memory_write_strobe_n,
  output logic ioReadStrobe_n,
  output logic ioWriteStrobe_n,
  output logic processorClockTick,
  output logic busClockTick,
  output logic timerClockTick,
  output logic displayClockTick,
  input wire logic dmaRequestPin,
  input wire logic [3:1] dmaChannelAck,
  output logic [3:1] dmaChannelRequest,
  output logic dmaAckPin_n
);
  import bcc_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] busCycleMode_r;
  logic [7:0] waitStateControlOne_r;
  logic [7:0] dmaMode_r;
  logic [7:0] platformConfig_r;
  logic wrPending_r;
  logic rdPending_r;
  logic [7:0] wrIndex_r;
  logic [7:0] rdIndex_r;
  logic cycleBusy;
  logic clocksRun;

  function automatic logic [7:0] addrToIndex(input logic [31:0] a);
    addrToIndex = a[9:2];
  endfunction

  function automatic logic [1:0] waitField(input logic [7:0] r, input int lsb);
    waitField = r[lsb +: 2];
  endfunction

  // zero wait for writes; reads take one wait because hrdata is registered from the pending read index
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPending_r <= 1'b0;
      rdPending_r <= 1'b0;
      wrIndex_r <= 8'h00;
      rdIndex_r <= 8'h00;
      hreadyout <= 1'b1;
    end
    else
    begin
      wrPending_r <= 1'b0;
      rdPending_r <= 1'b0;
      hreadyout <= 1'b1;
      if (hsel && hready && htrans[1] && hsize == 3'h2 && haddr[1:0] == 2'h0)
      begin
        if (hwrite)
        begin
          wrPending_r <= 1'b1;
          wrIndex_r <= addrToIndex(haddr);
        end
        else
        begin
          rdPending_r <= 1'b1;
          rdIndex_r <= addrToIndex(haddr);
          hreadyout <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end
    else if (rdPending_r)
    begin
      hresp <= 1'b0;
      case (rdIndex_r)
        IDX_BUS_CYCLE_MODE: hrdata <= {24'h000000, busCycleMode_r};
        IDX_WAIT_STATE_CONTROL_ONE: hrdata <= {24'h000000, waitStateControlOne_r};
        IDX_DMA_MODE: hrdata <= {24'h000000, dmaMode_r};
        IDX_PLATFORM_CONFIG: hrdata <= {24'h000000, platformConfig_r};
        IDX_CYCLE_STATUS: hrdata <= {28'h0000000, clocksRun, powerState, cycleBusy};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // unmapped writes are dropped silently
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      busCycleMode_r <= BUS_CYCLE_MODE_RST;
      waitStateControlOne_r <= WAIT_STATE_RST;
      dmaMode_r <= DMA_MODE_RST;
      platformConfig_r <= PLATFORM_CONFIG_RST;
    end
    else if (wrPending_r)
    begin
      case (wrIndex_r)
        IDX_BUS_CYCLE_MODE: busCycleMode_r <= hwdata[7:0];
        IDX_WAIT_STATE_CONTROL_ONE: waitStateControlOne_r <= hwdata[7:0];
        IDX_DMA_MODE: dmaMode_r <= {6'h00, hwdata[1:0]};
        IDX_PLATFORM_CONFIG: platformConfig_r <= {4'h0, hwdata[3:0]};
        default: ;
      endcase
    end
  end

  // ****************************************
  // clock divider chain
  // ****************************************
  logic [4:0] pmuDiv;
  logic [4:0] procDiv;
  logic [4:0] busDiv;
  logic [4:0] timerDiv;
  logic pmuTick;
  logic [2:0] procField;

  // oscillator derived clocks run only outside suspend and off
  assign clocksRun = (powerState == PWR_ON) || (powerState == PWR_DOZE);

  always_comb
  begin
    // slowest power state plus low speed reaches divide by eight
    case ({powerState == PWR_DOZE, platformConfig_r[SPEED_BIT]})
      2'b01: pmuDiv = 5'h01;
      2'b00: pmuDiv = 5'h02;
      2'b11: pmuDiv = 5'h04;
      default: pmuDiv = 5'h08;
    endcase
  end

  assign procField = busCycleMode_r[PROC_DIV_LSB +: 3];
  // field 7 saturates at eight rather than wrapping
  assign procDiv = (procField == 3'h7) ? 5'h08 : {2'b00, procField} + 5'h02;
  assign busDiv = {3'b000, busCycleMode_r[BUS_DIV_LSB +: 2]} + 5'h01;
  // 27 and 24 bring either crystal to the same timer rate
  assign timerDiv = busCycleMode_r[OSC_SEL_BIT] ? TIMER_DIV_HIGH_OSC : TIMER_DIV_LOW_OSC;

  // every derived clock starts from the oscillator tick
  bcc_clock_divider #(.W(5), .RESET_DIV(5'h01)) uPmuDiv (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(clocksRun),
    .tickIn(1'b1),
    .divisor(pmuDiv),
    .tickOut(pmuTick)
  );

  bcc_clock_divider #(.W(5), .RESET_DIV(5'h04)) uProcDiv (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(clocksRun),
    .tickIn(pmuTick),
    .divisor(procDiv),
    .tickOut(processorClockTick)
  );

  bcc_clock_divider #(.W(5), .RESET_DIV(5'h02)) uBusDiv (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(clocksRun),
    .tickIn(processorClockTick),
    .divisor(busDiv),
    .tickOut(busClockTick)
  );

  bcc_clock_divider #(.W(5), .RESET_DIV(5'h18)) uTimerDiv (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(clocksRun),
    .tickIn(1'b1),
    .divisor(timerDiv),
    .tickOut(timerClockTick)
  );

  bcc_clock_divider #(.W(5), .RESET_DIV(5'h02)) uDisplayDiv (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .run(clocksRun),
    .tickIn(1'b1),
    .divisor(DISPLAY_DIV),
    .tickOut(displayClockTick)
  );

  // ****************************************
  // bus cycle sequencer
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ROW,
    ST_ACTIVE,
    ST_DONE
  } bcc_state_t;

  bcc_state_t state_r;
  bcc_dev_t dev_r;
  logic write_r;
  logic [AW-1:0] addrHeld_r;
  logic [3:0] count_r;
  logic [3:0] loadCount;
  logic onBusClock;
  logic cycleTick;
  logic isMemDev;
  logic reqOnBus;
  logic [1:0] reqWait;
  logic strobeOn;

  assign isMemDev = (dev_r != DEV_IO) && (dev_r != DEV_EXPMEM) && (dev_r != DEV_INTIO);
  assign reqOnBus = (reqType == DEV_IO) || (reqType == DEV_EXPMEM) || (reqType == DEV_INTIO);
  assign onBusClock = !isMemDev;
  // memory cycles on processor ticks, io and expansion on bus ticks
  assign cycleTick = onBusClock ? busClockTick : processorClockTick;

  always_comb
  begin
    case (reqType)
      DEV_ROM0, DEV_ROM1: reqWait = waitField(waitStateControlOne_r, ROM_WAIT_LSB);
      DEV_RAM: reqWait = waitField(waitStateControlOne_r, RAM_WAIT_LSB);
      DEV_IO, DEV_INTIO: reqWait = waitField(waitStateControlOne_r, IO_WAIT_LSB);
      DEV_EXPMEM: reqWait = waitField(waitStateControlOne_r, EXP_WAIT_LSB);
      default: reqWait = 2'h0;
    endcase
  end

  // binary wait count stacked on the base length
  assign loadCount = (reqOnBus ? BUS_BASE_TICKS : MEM_BASE_TICKS) + {2'b00, reqWait};
  assign cycleBusy = (state_r != ST_IDLE);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      dev_r <= DEV_RAM;
      write_r <= 1'b0;
      count_r <= 4'h0;
      addrHeld_r <= '0;
      cycleDone <= 1'b0;
      laneEnable <= 2'b00;
    end
    else
    begin
      cycleDone <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (reqValid && clocksRun)
          begin
            dev_r <= reqType;
            write_r <= reqWrite;
            addrHeld_r <= reqAddr;
            count_r <= loadCount;
            // 8-bit ram or rom is only ever on the low lane
            if ((reqType == DEV_RAM && platformConfig_r[RAM8_BIT])
                || ((reqType == DEV_ROM0 || reqType == DEV_ROM1) && platformConfig_r[ROM8_BIT]))
              laneEnable <= 2'b01;
            else if (reqType == DEV_IO || reqType == DEV_INTIO || !reqWide)
              laneEnable <= reqAddr[0] ? 2'b10 : 2'b01;
            else
              laneEnable <= 2'b11;
            if (reqType == DEV_RAM && platformConfig_r[DRAM_BIT])
              state_r <= ST_ROW;
            else
              state_r <= ST_ACTIVE;
          end
        end
        ST_ROW:
        begin
          if (processorClockTick)
            state_r <= ST_ACTIVE;
        end
        ST_ACTIVE:
        begin
          if (cycleTick)
          begin
            if (count_r <= 4'h1)
              state_r <= ST_DONE;
            else
              count_r <= count_r - 4'h1;
          end
        end
        ST_DONE:
        begin
          cycleDone <= 1'b1;
          laneEnable <= 2'b00;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // pins
  // ****************************************
  // inhibited internal io runs its timing but shows no strobe
  assign strobeOn = (state_r == ST_ACTIVE)
                    && !(dev_r == DEV_INTIO && busCycleMode_r[CYCLE_INHIBIT_BIT]);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      addrOut <= '0;
      rowPhase <= 1'b0;
      memReadStrobe_n <= 1'b1;
      memWriteStrobe_n <= 1'b1;
      rom_select_zero_n <= 1'b1;
      rom_select_one_n <= 1'b1;
      expansion_memory_read_strobe_n <= 1'b1;
      expansion_memory_write_strobe_n <= 1'b1;
      ioReadStrobe_n <= 1'b1;
      ioWriteStrobe_n <= 1'b1;
    end
    else
    begin
      rowPhase <= (state_r == ST_ROW);
      // dram sees row then column; others see the latched address
      if (state_r == ST_ROW)
        addrOut <= {{(AW/2){1'b0}}, addrHeld_r[AW-1:AW/2]};
      else if (state_r == ST_ACTIVE && dev_r == DEV_RAM && platformConfig_r[DRAM_BIT])
        addrOut <= {{(AW/2){1'b0}}, addrHeld_r[AW/2-1:0]};
      else if (state_r == ST_ACTIVE && !(dev_r == DEV_INTIO && busCycleMode_r[CYCLE_INHIBIT_BIT]))
        addrOut <= addrHeld_r;
      else if (!busCycleMode_r[ADDR_LATCH_BIT])
        addrOut <= reqAddr; // latch bit off: address follows the requester
      memReadStrobe_n <= !(strobeOn && isMemDev && !write_r);
      memWriteStrobe_n <= !(strobeOn && isMemDev && write_r);
      rom_select_zero_n <= !(strobeOn && dev_r == DEV_ROM0);
      rom_select_one_n <= !(strobeOn && dev_r == DEV_ROM1);
      // only expansion memory cycles drive these strobes
      expansion_memory_read_strobe_n <= !(strobeOn && dev_r == DEV_EXPMEM && !write_r);
      expansion_memory_write_strobe_n <= !(strobeOn && dev_r == DEV_EXPMEM && write_r);
      ioReadStrobe_n <= !(strobeOn && (dev_r == DEV_IO || dev_r == DEV_INTIO) && !write_r);
      ioWriteStrobe_n <= !(strobeOn && (dev_r == DEV_IO || dev_r == DEV_INTIO) && write_r);
    end
  end

  // ****************************************
  // dma channel routing
  // ****************************************
  logic [1:0] dmaSel;
  assign dmaSel = dmaMode_r[DMA_SEL_LSB +: 2];

  // select zero leaves the pair disconnected
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      dmaChannelRequest <= 3'h0;
      dmaAckPin_n <= 1'b1;
    end
    else
    begin
      for (int ch = 1; ch <= 3; ch++)
        dmaChannelRequest[ch] <= dmaRequestPin && (dmaSel == 2'(ch));
      dmaAckPin_n <= !((dmaSel != 2'h0) && dmaChannelAck[dmaSel]);
    end
  end
endmodule
`default_nettype wire

//--- tb/bcc_top_asserts.sv
// port checker of the bus cycle clock generator
`timescale 1ns/10ps
`default_nettype none
module bcc_top_asserts (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [1:0] powerState,
  input wire logic dmaRequestPin,
  input wire logic cycleDone,
  input wire logic memReadStrobe_n,
  input wire logic memWriteStrobe_n,
  input wire logic rom_select_zero_n,
  input wire logic rom_select_one_n,
  input wire logic expansion_memory_read_strobe_n,
  input wire logic expansion_memory_write_strobe_n,
  input wire logic ioReadStrobe_n,
  input wire logic ioWriteStrobe_n,
  input wire logic processorClockTick,
  input wire logic busClockTick,
  input wire logic timerClockTick,
  input wire logic displayClockTick,
  input wire logic [3:1] dmaChannelRequest
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ****************
  // assertions
  // ****************
  exp_idle_a: assert property (
    (!memReadStrobe_n || !memWriteStrobe_n) |->
    (expansion_memory_read_strobe_n && expansion_memory_write_strobe_n))
    else $error("expansion strobe during memory cycle");
  io_excl_a: assert property (
    (!ioReadStrobe_n || !ioWriteStrobe_n) |->
    (memReadStrobe_n && memWriteStrobe_n && expansion_memory_read_strobe_n))
    else $error("io strobe overlaps memory strobe");
  rom_excl_a: assert property (
    !rom_select_zero_n |-> rom_select_one_n)
    else $error("both rom selects low");
  clocks_stop_a: assert property (
    powerState[1] [*3] |->
    !(processorClockTick || busClockTick || timerClockTick || displayClockTick))
    else $error("clock tick while suspended");
  proc_gap_a: assert property (
    processorClockTick |=> !processorClockTick)
    else $error("processor ticks too close");
  timer_gap_a: assert property (
    timerClockTick |=> !timerClockTick [*8])
    else $error("timer ticks too close");
  done_pulse_a: assert property (
    cycleDone |-> (memReadStrobe_n && ioReadStrobe_n && ioWriteStrobe_n) ##1 !cycleDone)
    else $error("cycle end pulse wrong");
  dma_route_a: assert property (
    (dmaChannelRequest != 3'h0) |-> ($onehot(dmaChannelRequest) && $past(dmaRequestPin)))
    else $error("dma request not routed to one channel");
  dma_drop_a: assert property (
    !dmaRequestPin |=> (dmaChannelRequest == 3'h0))
    else $error("dma request stays without pin");
  cover property (cycleDone);
  cover property (!ioReadStrobe_n);
  cover property (dmaChannelRequest[3]);
endmodule
bind bcc_top bcc_top_asserts u_bcc_top_asserts (
  .clk_sys, .resetn, .powerState, .dmaRequestPin, .cycleDone, .memReadStrobe_n,
  .memWriteStrobe_n, .rom_select_zero_n, .rom_select_one_n,
  .expansion_memory_read_strobe_n, .expansion_memory_write_strobe_n, .ioReadStrobe_n,
  .ioWriteStrobe_n, .processorClockTick, .busClockTick, .timerClockTick,
  .displayClockTick, .dmaChannelRequest
);
`default_nettype wire

//--- tb/bcc_ext_model.sv
// model of the memory and io devices on the shared bus
`timescale 1ns/10ps
`default_nettype none
module bcc_ext_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [5:0] strobes_n,
  input wire logic procTick,
  input wire logic busTick,
  input wire logic [1:0] laneEnable,
  input wire logic [19:0] addrOut,
  output logic [7:0] procCnt,
  output logic [7:0] busCnt,
  output logic [7:0] starts,
  output logic [1:0] lanes,
  output logic [19:0] lastAddr
);
  logic low;
  logic wasLow_r;
  logic procPrev_r;
  logic busPrev_r;
  // ****************
  // strobe watcher
  // ****************
  assign low = (strobes_n != 6'h3f);
  // ticks are counted one cycle late since strobes lag the cycle state
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      procPrev_r <= 1'b0;
      busPrev_r <= 1'b0;
      wasLow_r <= 1'b0;
      procCnt <= 8'h00;
      busCnt <= 8'h00;
      starts <= 8'h00;
      lanes <= 2'h0;
      lastAddr <= 20'h00000;
    end
    else
    begin
      procPrev_r <= procTick;
      busPrev_r <= busTick;
      wasLow_r <= low;
      if (low && !wasLow_r)
      begin
        procCnt <= {7'h00, procPrev_r};
        busCnt <= {7'h00, busPrev_r};
        starts <= starts + 8'h01;
        lanes <= laneEnable;
        lastAddr <= addrOut;
      end
      else if (low)
      begin
        procCnt <= procCnt + {7'h00, procPrev_r};
        busCnt <= busCnt + {7'h00, busPrev_r};
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/bcc_top_tb.sv
// self-checking bench of the bus cycle clock generator
`timescale 1ns/10ps
`default_nettype none
module bcc_top_tb;
  import bcc_pkg::*;
  logic clk_sys, resetn, hsel, hwrite, hready, hreadyout, hresp, reqValid, reqWrite, reqWide;
  logic cycleDone, rowPhase, mRd, mWr, r0, r1, eRd, eWr, iRd, iWr, pT, bT, tT, dT;
  logic dmaRequestPin, dmaAckPin_n;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, powerState, laneEnable, lanes;
  logic [2:0] hsize;
  logic [3:1] dmaChannelAck, dmaChannelRequest;
  logic [19:0] reqAddr, addrOut, lastAddr;
  logic [7:0] procCnt, busCnt, starts;
  bcc_dev_t reqType;
  bcc_dev_t kinds [6] = '{DEV_RAM, DEV_ROM0, DEV_ROM1, DEV_CARD1, DEV_IO, DEV_EXPMEM};
  int n_errors = 0;
  int comparisons = 0;
  int cnt;
  int rows = 0;
  assign hready = hreadyout;
  bcc_top u_bcc_top (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .powerState(powerState),
    .reqValid(reqValid), .reqType(reqType), .reqWrite(reqWrite), .reqWide(reqWide),
    .reqAddr(reqAddr), .cycleDone(cycleDone), .addrOut(addrOut), .rowPhase(rowPhase),
    .laneEnable(laneEnable), .memReadStrobe_n(mRd), .memWriteStrobe_n(mWr),
    .rom_select_zero_n(r0), .rom_select_one_n(r1), .expansion_memory_read_strobe_n(eRd),
    .expansion_memory_write_strobe_n(eWr), .ioReadStrobe_n(iRd), .ioWriteStrobe_n(iWr),
    .processorClockTick(pT), .busClockTick(bT), .timerClockTick(tT),
    .displayClockTick(dT), .dmaRequestPin(dmaRequestPin), .dmaChannelAck(dmaChannelAck),
    .dmaChannelRequest(dmaChannelRequest), .dmaAckPin_n(dmaAckPin_n));
  bcc_ext_model u_bcc_ext_model (.clk_sys(clk_sys), .resetn(resetn),
    .strobes_n({mRd, mWr, eRd, eWr, iRd, iWr}), .procTick(pT), .busTick(bT),
    .laneEnable(laneEnable), .addrOut(addrOut), .procCnt(procCnt), .busCnt(busCnt),
    .starts(starts), .lanes(lanes), .lastAddr(lastAddr));
  // ****************
  // tasks
  // ****************
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic final_report();
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang(input int n);
    if (n >= 2000)
    begin
      n_errors++;
      final_report();
    end
  endtask
  // ahb single word transfer; the slave may stretch either phase
  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    hsize <= 3'h2;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 2000);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 2000);
    q = hrdata;
    hang(n);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    ahb(1'b1, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    ahb(1'b0, idx, 8'h00);
    chk("register", {24'h0, exp}, q);
  endtask
  function automatic logic tick(input int s);
    return s == 0 ? pT : s == 1 ? bT : s == 2 ? tT : dT;
  endfunction
  // the first gap may straddle a divisor change, so the third one is judged
  task automatic per(input int sel, input int exp);
    int n;
    int m;
    n = 0;
    for (int k = 0; k < 3; k++)
    begin
      m = 0;
      do
      begin
        @(posedge clk_sys);
        m++;
        n++;
      end while (tick(sel) !== 1'b1 && n < 2000);
    end
    hang(n);
    chk("tick period", exp, m);
  endtask
  task automatic cyc(input bcc_dev_t t, input logic wide, input logic [19:0] a);
    int n;
    n = 0;
    reqValid <= 1'b1;
    reqType <= t;
    reqWide <= wide;
    reqAddr <= a;
    @(posedge clk_sys);
    reqValid <= 1'b0;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (rowPhase === 1'b1) rows++;
    end while (cycleDone !== 1'b1 && n < 2000);
    hang(n);
  endtask
  // ****************
  // main sequence
  // ****************
  initial
  begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    powerState = PWR_ON;
    reqValid = 1'b0;
    reqType = DEV_RAM;
    reqWrite = 1'b0;
    reqWide = 1'b0;
    reqAddr = 20'h0;
    dmaRequestPin = 1'b0;
    dmaChannelAck = 3'h0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(IDX_BUS_CYCLE_MODE, 8'h0a);
    rd(IDX_WAIT_STATE_CONTROL_ONE, 8'h00);
    rd(IDX_DMA_MODE, 8'h01);
    wr(8'h20, 8'h5a);
    rd(8'h20, 8'h00);
    per(0, 4);
    per(1, 8);
    per(2, 24);
    per(3, 2);
    wr(IDX_BUS_CYCLE_MODE, 8'h3f);
    rd(IDX_BUS_CYCLE_MODE, 8'h3f);
    per(0, 8);
    per(1, 32);
    per(2, 27);
    for (int f = 0; f < 4; f++)
    begin
      wr(IDX_BUS_CYCLE_MODE, 8'(f << 3));
      per(1, 2 * (f + 1));
    end
    per(0, 2);
    wr(IDX_BUS_CYCLE_MODE, 8'h0a);
    powerState <= PWR_DOZE;
    per(0, 16);
    powerState <= PWR_ON;
    wr(IDX_PLATFORM_CONFIG, 8'h00);
    per(0, 8);
    wr(IDX_PLATFORM_CONFIG, 8'h01);
    powerState <= PWR_SUSPEND;
    repeat (4) @(posedge clk_sys);
    cnt = 0;
    for (int k = 0; k < 64; k++)
    begin
      @(posedge clk_sys);
      if ((pT | bT | tT | dT) !== 1'b0) cnt++;
    end
    chk("ticks while suspended", 0, cnt);
    powerState <= PWR_ON;
    for (int w = 0; w < 4; w++)
    begin
      wr(IDX_WAIT_STATE_CONTROL_ONE, 8'(w * 85));
      reqWrite <= w[0];
      for (int k = 0; k < 6; k++)
      begin
        cyc(kinds[k], 1'b1, 20'h00100);
        if (k < 4)
          chk("memory ticks", k == 3 ? 2 : 2 + w, procCnt);
        else
          chk("bus ticks", 3 + w, busCnt);
      end
    end
    wr(IDX_WAIT_STATE_CONTROL_ONE, 8'h00);
    cyc(DEV_RAM, 1'b1, 20'h00100);
    chk("lanes", 2'h3, lanes);
    wr(IDX_PLATFORM_CONFIG, 8'h05);
    cyc(DEV_RAM, 1'b1, 20'h00101);
    chk("lanes", 2'h1, lanes);
    wr(IDX_PLATFORM_CONFIG, 8'h03);
    cyc(DEV_RAM, 1'b1, 20'h12344);
    chk("column address", 20'h00344, lastAddr);
    chk("row phase", 1, rows != 0);
    wr(IDX_PLATFORM_CONFIG, 8'h01);
    cnt = starts;
    cyc(DEV_INTIO, 1'b0, 20'h00040);
    chk("strobe count", cnt + 1, starts);
    wr(IDX_BUS_CYCLE_MODE, 8'h8a);
    cyc(DEV_INTIO, 1'b0, 20'h00040);
    chk("strobe count", cnt + 1, starts);
    wr(IDX_BUS_CYCLE_MODE, 8'h4a);
    cyc(DEV_RAM, 1'b0, 20'h12344);
    chk("cycle address", 20'h12344, lastAddr);
    reqAddr <= 20'h0abc0;
    repeat (3) @(posedge clk_sys);
    chk("held address", 20'h12344, addrOut);
    wr(IDX_BUS_CYCLE_MODE, 8'h0a);
    repeat (3) @(posedge clk_sys);
    chk("open address", 20'h0abc0, addrOut);
    for (int s = 1; s < 4; s++)
    begin
      wr(IDX_DMA_MODE, 8'(s));
      dmaRequestPin <= 1'b1;
      dmaChannelAck <= 3'(1 << (s - 1));
      repeat (3) @(posedge clk_sys);
      chk("dma request", 1 << (s - 1), dmaChannelRequest);
      chk("dma ack", 0, dmaAckPin_n);
      dmaRequestPin <= 1'b0;
      dmaChannelAck <= 3'h0;
    end
    final_report();
  end
endmodule
`default_nettype wire
